// >>> design/traverse_frequency_generator.sv
// Purpose: traverse (wobble) frequency reference for a drive
// Assumes: settings static while running; inputs synchronous
// Notes: output refreshed once per 0.01 s tick during traverse
`timescale 1ns/1ps
`default_nettype none
module traverse_frequency_generator
  import traverse_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run_cmd,
  input wire traverse_cfg_t cfg,
  input wire logic multifunction_input_n,
  input wire logic [FREQ_W-1:0] max_freq,
  output logic [FREQ_W-1:0] freq_ref,
  output logic traverse_active,
  output logic hold_active
);
  localparam int TW = $clog2(TICK_DIV + 1);

  // ==========================================================
  // Tick divider
  logic [TW-1:0] tick_cnt_q, tick_cnt_d; // Cycle count
  logic tick; // 0.01 s enable pulse

  // Next tick count
  always_comb begin
    tick = (tick_cnt_q == TW'(TICK_DIV - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
  end

  // Tick register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ==========================================================
  // Setting clean-up and derived values
  logic manual; // Manual mode selected
  logic term_on; // Traverse terminal active
  logic [FREQ_W-1:0] preset_c; // Preset, in range
  logic [FREQ_W-1:0] central_c; // Centre, in range
  logic [PCT_W-1:0] amp_c; // Amplitude pct
  logic [PCT_W-1:0] step_c; // Step pct
  logic [PCT_W-1:0] rise_c; // Rise share pct
  logic [PER_W-1:0] period_c; // Period in ticks
  logic [HOLD_W-1:0] hold_c; // Hold setting
  logic [FREQ_W+PCT_W-1:0] amp_prod; // Centre x pct
  logic [FREQ_W+PCT_W-1:0] step_prod; // Amp x pct
  logic [PER_W+PCT_W-1:0] rise_prod; // Period x pct
  logic [FREQ_W-1:0] amp_hz; // Swing amplitude
  logic [FREQ_W-1:0] step_hz; // Step jump
  logic [FREQ_W-1:0] span_hz; // Ramp travel
  logic [PER_W-1:0] rise_ticks; // Rising length
  logic [PER_W-1:0] fall_ticks; // Falling length
  logic [HOLD_CNT_W-1:0] hold_limit; // Hold in ticks
  logic signed [SW-1:0] low_base; // Rise start point
  logic signed [SW-1:0] high_base; // Fall start point
  logic [FREQ_W-1:0] preset_out; // Clamped preset

  // Saturating clamp of a signed value into 0..lim
  function automatic logic [FREQ_W-1:0] clamp_freq(
    input logic signed [SW-1:0] v,
    input logic [FREQ_W-1:0] lim
  );
    logic signed [SW-1:0] lim_s;
    lim_s = $signed({2'b00, lim});
    if (v < 0) begin
      clamp_freq = '0;
    end else if (v > lim_s) begin
      clamp_freq = lim;
    end else begin
      clamp_freq = v[FREQ_W-1:0];
    end
  endfunction

  // Derived waveform figures
  always_comb begin
    manual = (cfg.traverse_mode_select == MODE_MANUAL);
    term_on = !multifunction_input_n;
    // Limit settings to their legal ranges
    preset_c = (cfg.preset_wobble_freq > FREQ_SET_MAX) ?
               FREQ_SET_MAX : cfg.preset_wobble_freq;
    central_c = (cfg.central_freq > FREQ_SET_MAX) ?
                FREQ_SET_MAX : cfg.central_freq;
    amp_c = (cfg.swing_amplitude_pct > PCT_HALF) ?
            PCT_HALF : cfg.swing_amplitude_pct;
    step_c = (cfg.step_jump_pct > PCT_HALF) ?
             PCT_HALF : cfg.step_jump_pct;
    rise_c = (cfg.rise_share_pct > PCT_FULL) ?
             PCT_FULL : cfg.rise_share_pct;
    hold_c = (cfg.preset_hold_time > HOLD_SET_MAX) ?
             HOLD_SET_MAX : cfg.preset_hold_time;
    if (cfg.wobble_period < PER_SET_MIN) begin
      period_c = PER_SET_MIN;
    end else if (cfg.wobble_period > PER_SET_MAX) begin
      period_c = PER_SET_MAX;
    end else begin
      period_c = cfg.wobble_period;
    end
    // Amplitude from centre and percentage
    amp_prod = central_c * amp_c;
    amp_hz = FREQ_W'(amp_prod / PCT_FULL);
    // Step as share of amplitude; zero pct gives none
    step_prod = amp_hz * step_c;
    step_hz = FREQ_W'(step_prod / PCT_FULL);
    span_hz = {amp_hz[FREQ_W-2:0], 1'b0} - step_hz;
    // Rise and fall split of the period
    rise_prod = period_c * rise_c;
    rise_ticks = PER_W'(rise_prod / PCT_FULL);
    fall_ticks = period_c - rise_ticks;
    hold_limit = hold_c * TICKS_PER_HOLD_UNIT;
    // Ramp start points, step applied at each turn
    low_base = $signed({2'b00, central_c}) -
               $signed({2'b00, amp_hz}) +
               $signed({2'b00, step_hz});
    high_base = $signed({2'b00, central_c}) +
                $signed({2'b00, amp_hz}) -
                $signed({2'b00, step_hz});
    preset_out = clamp_freq($signed({2'b00, preset_c}),
                            max_freq);
  end

  // ==========================================================
  // Sequencer state
  trav_state_t st_q, st_d; // Operating state
  logic [HOLD_CNT_W-1:0] hold_cnt_q, hold_cnt_d; // Hold ticks
  logic [PER_W-1:0] phase_q, phase_d; // Tick in period
  logic rising_q, rising_d; // Segment of pending step
  logic [FREQ_W-1:0] freq_q, freq_d; // Output reference
  logic div_start; // Launch ramp division
  logic div_busy; // Divider running
  logic div_done; // Quotient ready
  logic [NUM_W-1:0] div_num; // Span x elapsed
  logic [PER_W-1:0] div_den; // Segment length
  logic [NUM_W-1:0] div_quot; // Ramp offset
  logic seg_rise; // Current tick is rising
  logic [PER_W-1:0] seg_pos; // Ticks into segment
  logic signed [SW-1:0] ramp_val; // Unclamped output

  // Next state, counters and output
  always_comb begin
    st_d = st_q;
    hold_cnt_d = hold_cnt_q;
    phase_d = phase_q;
    rising_d = rising_q;
    freq_d = freq_q;
    div_start = 1'b0;
    seg_rise = (phase_q < rise_ticks);
    seg_pos = seg_rise ? phase_q : phase_q - rise_ticks;
    div_num = span_hz * seg_pos;
    div_den = seg_rise ? rise_ticks : fall_ticks;
    ramp_val = rising_q ?
      low_base + $signed({2'b00, div_quot[FREQ_W-1:0]}) :
      high_base - $signed({2'b00, div_quot[FREQ_W-1:0]});
    if (!run_cmd) begin
      // Stopped: no reference
      st_d = ST_IDLE;
      freq_d = '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          // Start: auto holds, manual follows terminal
          hold_cnt_d = '0;
          phase_d = '0;
          if (!manual) begin
            st_d = ST_HOLD;
          end else if (term_on) begin
            st_d = ST_TRAVERSE;
          end else begin
            st_d = ST_PRESET;
          end
        end
        ST_HOLD: begin
          // Preset output for the hold time
          freq_d = preset_out;
          phase_d = '0;
          if (manual) begin
            // Hold time has no meaning here
            st_d = term_on ? ST_TRAVERSE : ST_PRESET;
          end else if (hold_cnt_q >= hold_limit) begin
            st_d = ST_TRAVERSE;
          end else if (tick) begin
            hold_cnt_d = hold_cnt_q + 1'b1;
          end
        end
        ST_PRESET: begin
          // Manual with terminal off
          freq_d = preset_out;
          phase_d = '0;
          if (!manual) begin
            hold_cnt_d = '0;
            st_d = ST_HOLD;
          end else if (term_on) begin
            st_d = ST_TRAVERSE;
          end
        end
        ST_TRAVERSE: begin
          // Triangular swing about the centre
          if (manual && !term_on) begin
            st_d = ST_PRESET;
            freq_d = preset_out;
          end else begin
            if (tick && !div_busy) begin
              div_start = 1'b1;
              rising_d = seg_rise;
              phase_d = (phase_q >= period_c - 1'b1) ?
                        '0 : phase_q + 1'b1;
            end
            if (div_done) begin
              freq_d = clamp_freq(ramp_val, max_freq);
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          freq_d = '0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      hold_cnt_q <= '0;
      phase_q <= '0;
      rising_q <= 1'b1;
      freq_q <= '0;
    end else begin
      st_q <= st_d;
      hold_cnt_q <= hold_cnt_d;
      phase_q <= phase_d;
      rising_q <= rising_d;
      freq_q <= freq_d;
    end
  end

  // ==========================================================
  // Ramp offset: span x elapsed / segment length
  serial_divider #(
    .NW(NUM_W),
    .DW(PER_W)
  ) u_ramp_div (
    .clk(clk),
    .reset_n(reset_n),
    .start(div_start),
    .numer(div_num),
    .denom(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // Outputs
  assign freq_ref = freq_q;
  assign traverse_active = (st_q == ST_TRAVERSE);
  assign hold_active = (st_q == ST_HOLD);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_AUTO_HOLD_EXIT: assert property (
    st_q == ST_HOLD && run_cmd && !manual &&
    hold_cnt_q >= hold_limit |=> st_q == ST_TRAVERSE)
    else $error("auto hold did not end on time");

  AST_HOLD_STAYS: assert property (
    st_q == ST_HOLD && run_cmd && !manual &&
    hold_cnt_q < hold_limit |=> st_q == ST_HOLD)
    else $error("auto hold left early");

  AST_MANUAL_ENTER: assert property (
    run_cmd && manual && term_on && st_q != ST_TRAVERSE
    |=> st_q == ST_TRAVERSE)
    else $error("terminal did not start traverse");

  AST_MANUAL_EXIT: assert property (
    run_cmd && manual && !term_on && st_q != ST_IDLE
    |=> st_q == ST_PRESET ##0 freq_ref == $past(preset_out))
    else $error("terminal off did not give preset");

  AST_MANUAL_NO_HOLD: assert property (
    manual && $past(manual) && $past(run_cmd)
    |-> st_q != ST_HOLD)
    else $error("manual mode used hold time");

  AST_PRESET_OUT: assert property (
    st_q == ST_HOLD && $past(st_q) == ST_HOLD
    |-> freq_ref == $past(preset_out))
    else $error("preset not output during hold");

  AST_PHASE_WRAP: assert property (
    st_q == ST_TRAVERSE && run_cmd && !manual && tick &&
    !div_busy && phase_q == period_c - 1'b1 |=> phase_q == '0)
    else $error("period did not wrap");

  AST_CLAMP: assert property (
    freq_ref <= $past(max_freq) || freq_ref == '0)
    else $error("output above maximum frequency");

  AST_RAMP_STEP: assert property (
    div_start |-> ##1 div_busy [*8])
    else $error("ramp division did not run");

  // Quotient must be ready 34 cycles after launch, inside one tick
  AST_RAMP_DONE: assert property (
    div_start |-> ##34 div_done)
    else $error("ramp division late");

  AST_IDLE_ZERO: assert property (
    !run_cmd |=> freq_ref == '0 && st_q == ST_IDLE)
    else $error("stopped generator still outputs");

endmodule // traverse_frequency_generator
`default_nettype wire

// >>> pkg/traverse_pkg.sv
// Purpose: constants and types for the traverse frequency generator
// Assumes: frequency in 0.01 Hz, hold in 0.1 s, period in 0.01 s
// Notes: percentages are in 0.1 % steps (1000 = 100.0 %)
//
// Operation
// - Auto mode: hold preset, then traverse
// - Manual mode: terminal active selects traverse
// - Manual mode ignores hold time setting
// - Auto hold time 0.0 to 3600 s
// - Preset frequency 0.00-400.0 Hz output first, except manual start with terminal active
// - Waveform centred on central frequency
// - Amplitude is centre times amplitude percent
// - Step jump percent; zero gives none
// - Period covers rise and fall, repeats
// - Rise share splits period into rise, fall
package traverse_pkg;

  // ==========================================================
  // Widths
  localparam int FREQ_W = 16; // 0.01 Hz units
  localparam int PCT_W = 10; // 0.1 % units
  localparam int HOLD_W = 16; // 0.1 s units
  localparam int PER_W = 17; // 0.01 s units
  localparam int HOLD_CNT_W = 19; // Hold count in ticks
  localparam int SW = FREQ_W + 2; // Signed working width
  localparam int NUM_W = FREQ_W + PER_W; // Ramp numerator

  // ==========================================================
  // Setting limits
  localparam logic [PCT_W-1:0] PCT_FULL = 10'h3e8; // 100.0 %
  localparam logic [PCT_W-1:0] PCT_HALF = 10'h1f4; // 50.0 %
  localparam logic [FREQ_W-1:0] FREQ_SET_MAX = 16'h9c40; // 400.00
  localparam logic [HOLD_W-1:0] HOLD_SET_MAX = 16'h8ca0; // 3600.0
  localparam logic [PER_W-1:0] PER_SET_MIN = 17'h0000a; // 0.10 s
  localparam logic [PER_W-1:0] PER_SET_MAX = 17'h1869e; // 999.98

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20; // 50 MHz
  localparam int TICK_NS = 10_000_000; // 0.01 s base tick
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [3:0] TICKS_PER_HOLD_UNIT = 4'ha; // 0.1 s

  // ==========================================================
  // Mode encodings
  localparam logic MODE_AUTO = 1'b0;
  localparam logic MODE_MANUAL = 1'b1;

  // Generator states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_PRESET,
    ST_TRAVERSE
  } trav_state_t;

  // Traverse settings carried together
  typedef struct packed {
    logic traverse_mode_select;
    logic [FREQ_W-1:0] preset_wobble_freq;
    logic [HOLD_W-1:0] preset_hold_time;
    logic [FREQ_W-1:0] central_freq;
    logic [PCT_W-1:0] swing_amplitude_pct;
    logic [PCT_W-1:0] step_jump_pct;
    logic [PER_W-1:0] wobble_period;
    logic [PCT_W-1:0] rise_share_pct;
  } traverse_cfg_t;

endpackage

// >>> design/serial_divider.sv
// Purpose: unsigned restoring divider, one quotient bit a cycle
// Assumes: denominator is non-zero when started
// Notes: busy for NW cycles, done pulses one cycle
`timescale 1ns/1ps
`default_nettype none
module serial_divider #(
  parameter int NW = 33,
  parameter int DW = 17
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [NW-1:0] numer,
  input wire logic [DW-1:0] denom,
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);
  localparam int CW = $clog2(NW + 1);

  // ==========================================================
  // State
  logic [DW:0] rem_q, rem_d; // Partial remainder
  logic [NW-1:0] quo_q, quo_d; // Shifting quotient
  logic [DW-1:0] den_q, den_d; // Latched divisor
  logic [CW-1:0] cnt_q, cnt_d; // Bits left
  logic done_q, done_d; // Finish pulse
  logic [DW:0] shifted; // Remainder after shift

  // Next state: shift, compare, subtract
  always_comb begin
    rem_d = rem_q;
    quo_d = quo_q;
    den_d = den_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    shifted = {rem_q[DW-1:0], quo_q[NW-1]};
    if (cnt_q != '0) begin
      // One restoring step
      if (shifted >= {1'b0, den_q}) begin
        rem_d = shifted - {1'b0, den_q};
        quo_d = {quo_q[NW-2:0], 1'b1};
      end else begin
        rem_d = shifted;
        quo_d = {quo_q[NW-2:0], 1'b0};
      end
      cnt_d = cnt_q - 1'b1;
      done_d = (cnt_q == CW'(1));
    end else if (start) begin
      // Load operands
      rem_d = '0;
      quo_d = numer;
      den_d = denom;
      cnt_d = CW'(NW);
    end
  end

  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      den_q <= den_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = done_q;
  assign quot = quo_q;
endmodule // serial_divider
`default_nettype wire

// >>> bench/drive_partner.sv
// Purpose: drive side model: run command, terminal, speed loop
// Assumes: requests come from the bench at the falling edge
// Notes: counts every cycle where the reference exceeds max_freq
`timescale 1ns/1ps
`default_nettype none
module drive_partner
  import traverse_pkg::*;
(
  input wire logic clk,
  input wire logic run_req,
  input wire logic term_req,
  input wire logic [FREQ_W-1:0] freq_ref,
  input wire logic [FREQ_W-1:0] max_freq,
  output logic run_cmd,
  output logic multifunction_input_n,
  output logic [15:0] over_cnt
);
  // ==========================================================
  // Terminal and run command
  assign run_cmd = run_req; // Drive running level
  assign multifunction_input_n = ~term_req; // Terminal is active low

  // ==========================================================
  // Speed loop watch: reference must stay within drive limit
  // One process owns the counter: cleared at start, then counts
  initial begin
    over_cnt = 16'h0000;
    forever begin
      @(posedge clk);
      if (freq_ref > max_freq) begin
        over_cnt <= over_cnt + 16'h0001;
      end
    end
  end
endmodule // drive_partner
`default_nettype wire

// >>> bench/traverse_frequency_generator_bench.sv
// Purpose: self-checking bench for the traverse generator
// Assumes: short tick of 40 cycles; settings change only while idle
// Notes: auto run with hold and step, then manual run without step
`timescale 1ns/1ps
`default_nettype none
module traverse_frequency_generator_bench
  import traverse_pkg::*;
();
  localparam int TDIV = 40; // Short tick for simulation
  logic clk; // System clock
  logic reset_n; // Active low reset
  logic run_req; // Run request to partner
  logic term_req; // Terminal request to partner
  logic run_cmd;
  logic multifunction_input_n;
  traverse_cfg_t cfg; // Settings
  logic [FREQ_W-1:0] max_freq;
  logic [FREQ_W-1:0] freq_ref;
  logic traverse_active;
  logic hold_active;
  logic [15:0] over_cnt; // Limit violations seen by partner
  int n_mismatch;
  int total_checks;

  // ==========================================================
  // Instances
  traverse_frequency_generator #(
    .TICK_DIV(TDIV)
  ) u_traverse_frequency_generator (
    .clk(clk), .reset_n(reset_n), .run_cmd(run_cmd), .cfg(cfg),
    .multifunction_input_n(multifunction_input_n), .max_freq(max_freq),
    .freq_ref(freq_ref), .traverse_active(traverse_active),
    .hold_active(hold_active));
  drive_partner u_drive_partner (
    .clk(clk), .run_req(run_req), .term_req(term_req),
    .freq_ref(freq_ref), .max_freq(max_freq), .run_cmd(run_cmd),
    .multifunction_input_n(multifunction_input_n), .over_cnt(over_cnt));

  // Clock, 20 ns period
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Move to a later falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Expected reference at phase p
  function automatic int wave(input int p);
    int c, a, s, sp, r, pe, v;
    c = int'(cfg.central_freq);
    pe = int'(cfg.wobble_period);
    a = c * int'(cfg.swing_amplitude_pct) / 1000;
    s = a * int'(cfg.step_jump_pct) / 1000;
    sp = 2 * a - s;
    r = pe * int'(cfg.rise_share_pct) / 1000;
    if (p < r) v = c - a + s + sp * p / r;
    else v = c + a - s - sp * (p - r) / (pe - r);
    if (v > int'(max_freq)) v = int'(max_freq);
    if (v < 0) v = 0;
    return v;
  endfunction

  // Follow n ramp updates from the first one after entry
  task automatic sweep(input int n);
    int k;
    int e;
    k = 0;
    while (freq_ref === cfg.preset_wobble_freq && k < 4 * TDIV) begin
      cyc(1);
      k++;
    end
    // A first update that never comes is a failure
    check(k < 4 * TDIV, 1'b1);
    for (int p = 0; p < n; p++) begin
      e = wave(p % int'(cfg.wobble_period));
      check(freq_ref, e);
      cyc(TDIV);
    end
  endtask

  // ==========================================================
  // Auto mode: hold preset, then traverse with step and clamp
  task automatic t_auto();
    int n;
    cfg = '{1'b0, 16'h1388, 16'h0001, 16'h2710, 10'h0c8, 10'h064,
            17'h0000a, 10'h12c};
    max_freq = 16'h2af8;
    term_req = 1'b1; // Terminal ignored in auto
    run_req = 1'b1;
    cyc(3);
    check(hold_active, 1'b1);
    check(traverse_active, 1'b0);
    check(freq_ref, 32'h1388);
    n = 0;
    while (traverse_active !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    check(n >= 9 * TDIV - 5 && n <= 11 * TDIV, 1'b1);
    check(hold_active, 1'b0);
    sweep(12);
    run_req = 1'b0;
    cyc(3);
    check(freq_ref, 32'h0);
  endtask

  // ==========================================================
  // Manual mode: terminal alone controls traverse, no step
  task automatic t_manual();
    cfg = '{1'b1, 16'h1388, 16'h8ca0, 16'h2710, 10'h0c8, 10'h000,
            17'h0000a, 10'h12c};
    max_freq = 16'h9c40;
    term_req = 1'b0;
    run_req = 1'b1;
    cyc(20);
    check(hold_active, 1'b0);
    check(traverse_active, 1'b0);
    check(freq_ref, 32'h1388);
    term_req = 1'b1;
    cyc(2);
    check(traverse_active, 1'b1);
    sweep(4);
    term_req = 1'b0;
    cyc(1);
    check(traverse_active, 1'b0);
    check(freq_ref, 32'h1388);
    run_req = 1'b0;
    cyc(3);
  endtask

  // ==========================================================
  // Verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog on a hang
  initial begin
    #(20 * 10000);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    reset_n = 1'b0;
    run_req = 1'b0;
    term_req = 1'b0;
    cfg = '0;
    max_freq = 16'h2af8;
    cyc(8);
    check(traverse_active, 1'b0);
    reset_n = 1'b1;
    cyc(2);
    t_auto();
    t_manual();
    check(over_cnt, 32'h0);
    end_of_test();
  end
endmodule // traverse_frequency_generator_bench
`default_nettype wire
